// ===== src/gamma_dac_regs.vh
// constants for the gamma reference write path over the two-wire bus
// assumes a single core clock and bus pins already synchronous to it
`ifndef GAMMA_DAC_REGS_VH
`define GAMMA_DAC_REGS_VH

// fixed upper six bits of the 7-bit target address
`define ADDR_FIXED 6'h3A
// direction bit value for a write
`define DIR_WRITE 1'b0
// register pointers
`define PTR_CTRL 8'h00
`define PTR_DAC_FIRST 8'h01
`define PTR_DAC_LAST 8'h0F
`define PTR_BEYOND 8'h10
`define PTR_STEP 8'h01
// control byte recall command and output disable bit
`define CTRL_RECALL 8'h06
`define CTRL_OUT_DIS_BIT 3
// upper byte field positions: word bit 14 is upper byte bit 6, bits 9:8 are 1:0
`define UPPER_NV_BIT 6
`define UPPER_DATA_HI 1
// word geometry
`define DAC_COUNT 15
`define DAC_WIDTH 10
`define DAC_BUS_WIDTH 150
`define DAC_ZERO 10'h000
// bit counter
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define BIT_ZERO 4'h0
`define BIT_STEP 4'h1
// protocol states
`define ST_IDLE 3'h0
`define ST_ADDR 3'h1
`define ST_PTR 3'h2
`define ST_DATA 3'h3
`define ST_SKIP 3'h4

`endif

// ===== src/dac_word_reg.v
// one 10-bit DAC holding register
// assumes load and recall never coincide; recall copies stored contents
`timescale 1ns/1ns
`include "gamma_dac_regs.vh"

module dac_word_reg (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // update sources
  input wire load_i,
  input wire [`DAC_WIDTH-1:0] load_value_i,
  input wire recall_i,
  input wire [`DAC_WIDTH-1:0] recall_value_i,
  // held value
  output reg [`DAC_WIDTH-1:0] value_o
);

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      value_o <= `DAC_ZERO;
    end else if (recall_i) begin
      value_o <= recall_value_i;
    end else if (load_i) begin
      value_o <= load_value_i;
    end
  end

endmodule

// ===== src/gamma_dac_i2c_write_handler.v
// target-side write path of a gamma reference buffer on a two-wire bus
// assumes scl and sda inputs already synchronous to clk_i; sda pulled up outside
// a read request (direction bit 1) is left unanswered
//
// Overview of operation
// - pointer zero control, one to fifteen words
// - control byte 0x06 recalls stored contents
// - second byte at pointer zero discarded
// - first byte upper, second lower
// - further pairs fill following words
// - third consecutive word lower byte acknowledged
// - channel updates only on full word or on recall
// - address mismatch ignored until next start
// - pointer advances after every byte pair, then holds at 0x10
// - bits 9:0 value, bit 14 storage
`timescale 1ns/1ns
`include "gamma_dac_regs.vh"

module gamma_dac_i2c_write_handler (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // bus pins
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  // address strap
  input wire address_select_pin_i,
  // stored non-volatile contents, word 1 in the low bits
  input wire [`DAC_BUS_WIDTH-1:0] nv_data_i,
  // DAC holding registers, word 1 in the low bits
  output wire [`DAC_BUS_WIDTH-1:0] dac_value_o,
  // control
  output reg outputs_disabled_o,
  output reg recall_o,
  // storage write request
  output reg nv_write_o,
  output reg [3:0] nv_index_o,
  output reg [`DAC_WIDTH-1:0] nv_value_o
);

  // previous bus samples
  reg scl_q;
  reg sda_q;
  // byte framing
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg acking;
  // register pointer and pending upper byte
  reg [7:0] ptr;
  reg second;
  reg [7:0] upper;
  // word load handed to the holding registers
  reg load_en;
  reg [3:0] load_idx;
  reg [`DAC_WIDTH-1:0] load_value;

  // bus events against the previous samples
  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire start_cond = scl_i & scl_q & sda_q & ~sda_i;
  wire stop_cond = scl_i & scl_q & ~sda_q & sda_i;
  wire byte_done = scl_fall & (bit_cnt == `BIT_ACK) & ~acking;
  wire ack_done = scl_fall & acking;
  // the ninth rise belongs to the ack slot, not to the data
  wire bit_take = scl_rise & (bit_cnt <= `BIT_LAST) & ~acking;

  // byte decode
  wire addr_match = (shift[7:1] == {`ADDR_FIXED, address_select_pin_i});
  wire addr_ours = addr_match & (shift[0] == `DIR_WRITE);
  wire ptr_is_dac = (ptr >= `PTR_DAC_FIRST) && (ptr <= `PTR_DAC_LAST);
  wire [7:0] next_ptr = ptr + `PTR_STEP;
  wire [`DAC_WIDTH-1:0] full_word = {upper[`UPPER_DATA_HI:0], shift};

  // copies reset to the idle level so release shows no false edge
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= `ST_IDLE;
      bit_cnt <= `BIT_ZERO;
      shift <= 8'h00;
      acking <= 1'b0;
      ptr <= `PTR_CTRL;
      second <= 1'b0;
      upper <= 8'h00;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      outputs_disabled_o <= 1'b0;
      recall_o <= 1'b0;
      nv_write_o <= 1'b0;
      nv_index_o <= 4'h0;
      nv_value_o <= `DAC_ZERO;
      load_en <= 1'b0;
      load_idx <= 4'h0;
      load_value <= `DAC_ZERO;
    end else begin
      recall_o <= 1'b0;
      nv_write_o <= 1'b0;
      load_en <= 1'b0;
      if (start_cond) begin
        state <= `ST_ADDR;
        bit_cnt <= `BIT_ZERO;
        acking <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop_cond) begin
        state <= `ST_IDLE;
        bit_cnt <= `BIT_ZERO;
        acking <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (state == `ST_IDLE || state == `ST_SKIP) begin
        sda_oe_o <= 1'b0;
      end else if (bit_take) begin
        shift <= {shift[6:0], sda_i};
        bit_cnt <= bit_cnt + `BIT_STEP;
      end else if (ack_done) begin
        // release the line after the ninth clock
        acking <= 1'b0;
        sda_oe_o <= 1'b0;
        bit_cnt <= `BIT_ZERO;
      end else if (byte_done) begin
        case (state)
          `ST_ADDR: begin
            if (addr_ours) begin
              state <= `ST_PTR;
              acking <= 1'b1;
              sda_oe_o <= 1'b1;
            end else begin
              state <= `ST_SKIP;
              bit_cnt <= `BIT_ZERO;
            end
          end
          `ST_PTR: begin
            ptr <= shift;
            second <= 1'b0;
            state <= `ST_DATA;
            acking <= 1'b1;
            sda_oe_o <= 1'b1;
          end
          `ST_DATA: begin
            acking <= 1'b1;
            sda_oe_o <= 1'b1;
            second <= ~second;
            if (ptr == `PTR_CTRL) begin
              if (!second) begin
                // a recall and a word load never fall in one cycle
                // recall command
                recall_o <= (shift == `CTRL_RECALL);
                outputs_disabled_o <= shift[`CTRL_OUT_DIS_BIT];
              end else begin
                ptr <= next_ptr;
              end
            end else if (ptr_is_dac) begin
              if (!second) begin
                upper <= shift;
              end else begin
                load_en <= 1'b1;
                load_idx <= ptr[3:0];
                load_value <= full_word;
                nv_write_o <= upper[`UPPER_NV_BIT];
                nv_index_o <= ptr[3:0];
                nv_value_o <= full_word;
                ptr <= next_ptr;
              end
            end else begin
              ptr <= `PTR_BEYOND;
            end
          end
          default: begin
            state <= `ST_IDLE;
            bit_cnt <= `BIT_ZERO;
          end
        endcase
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `DAC_COUNT; g = g + 1) begin : gen_word
      localparam [31:0] WORD_NUM = g + 1;
      // only the addressed word takes the load
      wire word_hit = load_en && (load_idx == WORD_NUM[3:0]);
      dac_word_reg u_word (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .load_i(word_hit),
        .load_value_i(load_value),
        .recall_i(recall_o),
        .recall_value_i(nv_data_i[g*`DAC_WIDTH +: `DAC_WIDTH]),
        .value_o(dac_value_o[g*`DAC_WIDTH +: `DAC_WIDTH])
      );
    end
  endgenerate

endmodule

// ===== bench/i2c_master_model.sv
// bus master model for the gamma write path
// assumes sda pulled up; target only pulls low
`timescale 1ns/1ns
module i2c_master_model (
  input wire clk_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_o,
  output reg ack_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    ack_o = 1'b0;
  end
  task hold;
    repeat (3) @(negedge clk_i);
  endtask
  task start;
    begin
      sda_o = 1'b1; hold; scl_o = 1'b1; hold;
      sda_o = 1'b0; hold; scl_o = 1'b0; hold;
    end
  endtask
  task stop;
    begin
      sda_o = 1'b0; hold; scl_o = 1'b1; hold; sda_o = 1'b1; hold;
    end
  endtask
  task wbyte(input [7:0] b);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sda_o = b[i]; hold; scl_o = 1'b1; hold; scl_o = 1'b0;
      end
      sda_o = 1'b1; hold; ack_o = !sda_i; scl_o = 1'b1; hold; scl_o = 1'b0;
    end
  endtask
endmodule

// ===== bench/gamma_dac_write_checker.sv
// port assertions for the gamma write path
// assumes bus pins synchronous to clk_i
`timescale 1ns/1ns
`include "gamma_dac_regs.vh"
module gamma_dac_write_checker (
  input wire clk_i, arst_n_i, scl_i, sda_o, sda_oe_o, recall_o, nv_write_o,
  input wire [3:0] nv_index_o,
  input wire [`DAC_WIDTH-1:0] nv_value_o,
  input wire [`DAC_BUS_WIDTH-1:0] nv_data_i, dac_value_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_ack_scl_low: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("ack raised while scl high");
  a_ack_drives_low: assert property (sda_oe_o |-> !sda_o)
    else $error("ack not low");
  a_recall_pulse: assert property (recall_o |=> !recall_o)
    else $error("recall pulse too long");
  a_recall_copy: assert property (recall_o |=> dac_value_o == $past(nv_data_i))
    else $error("recall did not copy");
  a_store_pulse: assert property (nv_write_o |=> !nv_write_o)
    else $error("store pulse too long");
  a_index_range: assert property (nv_write_o |-> nv_index_o inside {[1:15]})
    else $error("store index out of range");
  a_word_loaded: assert property (nv_write_o |=>
    dac_value_o[($past(nv_index_o) - 4'h1) * 10 +: 10] == $past(nv_value_o))
    else $error("word not loaded");
  a_dac_in_ack: assert property (!$stable(dac_value_o) |-> sda_oe_o)
    else $error("dac changed outside ack");
  cover property (recall_o);
  cover property (nv_write_o);
  cover property ($rose(sda_oe_o));
endmodule
bind gamma_dac_i2c_write_handler gamma_dac_write_checker chk (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .recall_o(recall_o), .nv_write_o(nv_write_o), .nv_index_o(nv_index_o),
  .nv_value_o(nv_value_o), .nv_data_i(nv_data_i), .dac_value_o(dac_value_o));

// ===== bench/test_gamma_dac_i2c_write_handler.sv
// self-checking bench for the gamma write path
// assumes the master model drives the bus
`timescale 1ns/1ns
module test_gamma_dac_i2c_write_handler;
  reg clk_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg sel = 1'b0;
  wire scl, sda_m, sda_d, sda_oe, ack;
  wire sda = sda_m & ~(sda_oe & ~sda_d);
  wire [149:0] dac;
  // words 1, 2 and 3 of the stored contents differ so a mis-ordered recall shows
  wire [149:0] nv = {5{30'h2A570CF6}};
  wire dis, nv_wr;
  wire [3:0] nv_idx;
  wire [9:0] nv_val;
  reg [9:0] nv_count = 10'h000;
  integer fails = 0;
  integer comparisons = 0;
  initial forever #2 clk_i = ~clk_i;
  gamma_dac_i2c_write_handler DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_d), .sda_oe_o(sda_oe), .address_select_pin_i(sel),
    .nv_data_i(nv), .dac_value_o(dac), .outputs_disabled_o(dis), .recall_o(),
    .nv_write_o(nv_wr), .nv_index_o(nv_idx), .nv_value_o(nv_val));
  i2c_master_model M (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_m), .ack_o(ack));
  // counts storage write pulses
  always @(posedge clk_i) begin
    if (nv_wr) begin
      nv_count <= nv_count + 10'h001;
    end
  end
  task chk(input [9:0] got, input [9:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_ack(input got, input exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("MISMATCH %0t ack got %b expected %b", $time, got, exp);
      end
    end
  endtask
  task sb(input [7:0] b, input e);
    begin
      M.wbyte(b);
      chk_ack(ack, e);
    end
  endtask
  function [9:0] w(input integer k);
    w = dac[(k - 1) * 10 +: 10];
  endfunction
  task s_burst;
    begin
      M.start;
      sb(8'hE8, 1'b1);
      sb(8'h01, 1'b1);
      sb(8'h40, 1'b1);
      sb(8'h12, 1'b1);
      sb(8'h02, 1'b1);
      sb(8'h34, 1'b1);
      sb(8'h03, 1'b1);
      sb(8'hFF, 1'b1);
      M.stop;
      chk(w(1), 10'h012);
      chk(w(2), 10'h234);
      chk(w(3), 10'h3FF);
      chk(nv_count, 10'h001);
      chk({6'h00, nv_idx}, 10'h003);
      chk(nv_val, 10'h3FF);
    end
  endtask
  task s_half;
    begin
      M.start;
      sb(8'hE8, 1'b1);
      sb(8'h05, 1'b1);
      sb(8'h03, 1'b1);
      M.stop;
      chk(w(5), 10'h000);
    end
  endtask
  task s_recall;
    begin
      @(negedge clk_i) sel = 1'b1;
      M.start;
      sb(8'hE8, 1'b0);
      sb(8'h01, 1'b0);
      M.start;
      sb(8'hEA, 1'b1);
      sb(8'h00, 1'b1);
      sb(8'h06, 1'b1);
      sb(8'hFF, 1'b1);
      sb(8'h41, 1'b1);
      sb(8'h55, 1'b1);
      M.stop;
      chk(w(1), 10'h155);
      chk(w(2), 10'h1C3);
      chk(nv_count, 10'h002);
      chk(nv_val, 10'h155);
    end
  endtask
  task s_ctrl;
    begin
      M.start;
      sb(8'hEA, 1'b1);
      sb(8'h00, 1'b1);
      sb(8'h08, 1'b1);
      M.stop;
      chk({9'h000, dis}, 10'h001);
      chk(w(3), 10'h2A5);
    end
  endtask
  task s_beyond;
    begin
      M.start;
      sb(8'hEA, 1'b1);
      sb(8'h0F, 1'b1);
      sb(8'h02, 1'b1);
      sb(8'h22, 1'b1);
      sb(8'h03, 1'b1);
      sb(8'h33, 1'b1);
      M.stop;
      chk(w(15), 10'h222);
      chk(w(1), 10'h155);
      chk({6'h00, nv_idx}, 10'h00F);
    end
  endtask
  task report_and_stop;
    begin
      if (fails == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    s_burst;
    s_half;
    s_recall;
    s_ctrl;
    s_beyond;
    report_and_stop;
  end
  initial begin
    #100000;
    fails = fails + 1;
    report_and_stop;
  end
endmodule
